// file: hs_params.svh
/*
  Constants of the humidity sensor two-wire command port: bus address,
  command codes, configuration defaults, checksum and result formats.
  Assumes inclusion by its bare name from the checksum unit and the top module.
*/
`ifndef HS_PARAMS_SVH
`define HS_PARAMS_SVH

// Bus address, upper six bits
`define ADDR_BASE 6'h20

// Command codes
`define CMD_HUM_HOLD 8'he5
`define CMD_HUM_POLL 8'hf5
`define CMD_TEMP_HOLD 8'he3
`define CMD_TEMP_POLL 8'hf3
`define CMD_AUX 8'hee
`define CMD_LAST_TEMP 8'he0
`define CMD_RESET 8'hfe
`define CMD_WR_REG2 8'h50
`define CMD_RD_REG2 8'h10
`define CMD_WR_REG1 8'he6
`define CMD_RD_REG1 8'he7
`define CMD_WR_REG3 8'h51
`define CMD_RD_REG3 8'h11
`define CMD_WR_COEF 8'hc5
`define CMD_RD_COEF 8'h84
`define CMD_ID1 8'hfa
`define CMD_ID2 8'hfc
`define SUB_ID1 8'h0f
`define SUB_ID2 8'hc9
`define SUB_FW 8'hb8

// Configuration defaults and fields
`define REG1_RESET 8'h00
`define REG2_RESET 8'h00
`define REG3_RESET 8'h00
`define REG2_POLL_BIT 6

// Coefficient location range
`define COEF_LO 8'h82
`define COEF_HI 8'hb7

// Checksum
`define CRC_POLY 8'h31
`define CRC_INIT 8'h00

// Result tails
`define HUM_TAIL 2'b10
`define TEMP_TAIL 2'b00

`endif

// file: hs_pkg.sv
/*
  Types of the humidity sensor command port: bus state machine, read
  source selection and conversion kind.
  Assumes the constants header is on the include path.
*/
package hs_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RX = 6'b000010,
    ST_RACK = 6'b000100,
    ST_TX = 6'b001000,
    ST_TACK = 6'b010000,
    ST_HOLD = 6'b100000
  } fsm_type;

  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_HUM = 4'h1,
    SEL_TEMP = 4'h2,
    SEL_AUX = 4'h3,
    SEL_LAST_T = 4'h4,
    SEL_REG1 = 4'h5,
    SEL_REG2 = 4'h6,
    SEL_REG3 = 4'h7,
    SEL_COEF = 4'h8,
    SEL_FW = 4'h9,
    SEL_ID1 = 4'ha,
    SEL_ID2 = 4'hb
  } rsel_type;

  typedef enum logic [1:0] {
    CONV_HUM = 2'h0,
    CONV_TEMP = 2'h1,
    CONV_AUX = 2'h2
  } conv_type;

endpackage : hs_pkg

// file: crc_if.sv
/*
  Carrier between the command port and its checksum unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface crc_if;
  logic clr;
  logic upd;
  logic [7:0] data;
  logic [7:0] value;

  modport engine (output clr, output upd, output data, input value);
  modport unit (input clr, input upd, input data, output value);
endinterface : crc_if

// file: crc8_unit.sv
/*
  Byte-wide checksum accumulator for returned data bytes.
  Assumes clr and upd are one-cycle strobes from the command port.
*/
`timescale 1ns/1ps
module crc8_unit
  import hs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Checksum carrier
  crc_if.unit cif
);
  `include "hs_params.svh"

  logic [7:0] crc_q;

  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      crc_q <= `CRC_INIT;
    end else if (cif.upd) begin
      crc_q <= crc_step(cif.clr ? `CRC_INIT : crc_q, cif.data);
    end
  end

  assign cif.value = crc_q;

endmodule : crc8_unit

// file: humidity_sensor_i2c_command_port.sv
/*
  Two-wire target port and command interpreter of the humidity sensor.
  Assumes SCL and SDA arrive synchronous to core_clk and are oversampled
  well above the bus rate; the front end pulses conv_done with results.
*/
`timescale 1ns/1ps
module humidity_sensor_i2c_command_port
  import hs_pkg::*;
#(
  parameter logic [31:0] ID1_WORD = 32'h01020304, // arbitrary value
  parameter logic [31:0] ID2_WORD = 32'h05060708, // arbitrary value
  parameter logic [7:0] FW_REV = 8'h11, // arbitrary value
  parameter int ID_BYTES = 4
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Two-wire bus
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_pin,
  // Conversion front end
  output logic conv_start,
  output conv_type conv_kind,
  output logic conv_abort,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  input wire logic [15:0] conv_comp_temp,
  // Coefficient memory
  output logic coef_wr,
  output logic [7:0] coef_addr,
  output logic [7:0] coef_wdata,
  input wire logic [7:0] coef_rdata,
  // Configuration
  output logic [7:0] user_reg1,
  output logic [7:0] user_reg2,
  output logic [7:0] user_reg3
);
  `include "hs_params.svh"

  if (ID_BYTES < 1 || ID_BYTES > 4) begin : g_bad_id
    $error("ID_BYTES must lie between 1 and 4");
  end

  localparam logic [2:0] ID_LEN = 3'(ID_BYTES);

  fsm_type state_q;
  rsel_type rd_sel_q;
  conv_type kind_q;
  logic scl_prev_q, sda_prev_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [1:0] byte_idx_q;
  logic ack_q, rd_xfer_q, mack_q, crc_pend_q;
  logic [31:0] tx_buf_q;
  logic [2:0] tx_left_q;
  logic sda_oe_q, scl_oe_q;
  logic busy_q, poll_q, start_q, abort_q;
  logic [15:0] result_q, last_temp_q;
  logic [7:0] cmd_q, reg1_q, reg2_q, reg3_q;
  logic [7:0] caddr_q, cdata_q;
  logic cwr_q;

  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic byte_done, cmd_strobe, arg_strobe, data_strobe;
  logic addr_hit, addr_ok, rx_ack, src_wait;
  logic load_first, load_next, load_crc;
  logic [31:0] src_word;
  logic [2:0] src_len;
  logic src_crc;

  crc_if cif ();

  crc8_unit u_crc (
    .core_clk(core_clk),
    .rst(rst),
    .cif(cif)
  );

  // Bus events
  assign scl_rise = scl_in & ~scl_prev_q;
  assign scl_fall = ~scl_in & scl_prev_q;
  assign start_seen = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
  assign stop_seen = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
  assign byte_done = (state_q == ST_RX) && scl_fall && (bit_cnt_q == 4'h8);
  assign cmd_strobe = byte_done && (byte_idx_q == 2'h1);
  assign arg_strobe = byte_done && (byte_idx_q == 2'h2);
  assign data_strobe = byte_done && (byte_idx_q == 2'h3);

  assign addr_hit = shift_q[7:1] == {`ADDR_BASE, address_select_pin};
  assign addr_ok = addr_hit & ~(shift_q[0] & poll_q & busy_q);
  assign rx_ack = (byte_idx_q == 2'h0) ? addr_ok : 1'b1;

  assign src_wait = busy_q &&
    (rd_sel_q == SEL_HUM || rd_sel_q == SEL_TEMP || rd_sel_q == SEL_AUX);

  assign load_first =
    ((state_q == ST_RACK) && scl_fall && ack_q && rd_xfer_q && !src_wait) ||
    ((state_q == ST_HOLD) && !busy_q);
  assign load_next = (state_q == ST_TACK) && scl_fall && mack_q &&
    (tx_left_q > 3'h1);
  assign load_crc = (state_q == ST_TACK) && scl_fall && mack_q &&
    (tx_left_q == 3'h1) && crc_pend_q;

  assign cif.clr = load_first;
  assign cif.upd = load_first | load_next;
  assign cif.data = load_first ? src_word[31:24] : tx_buf_q[23:16];

  // Read source selection
  always_comb begin
    src_word = 32'h0;
    src_len = 3'h1;
    src_crc = 1'b0;
    unique case (rd_sel_q)
      SEL_HUM, SEL_TEMP: begin
        src_word = {result_q, 16'h0};
        src_len = 3'h2;
        src_crc = 1'b1;
      end
      SEL_AUX: begin
        src_word = {result_q, 16'h0};
        src_len = 3'h2;
      end
      SEL_LAST_T: begin
        src_word = {last_temp_q, 16'h0};
        src_len = 3'h2;
      end
      SEL_REG1: src_word = {reg1_q, 24'h0};
      SEL_REG2: src_word = {reg2_q, 24'h0};
      SEL_REG3: src_word = {reg3_q, 24'h0};
      SEL_COEF: src_word = {coef_rdata, 24'h0};
      SEL_FW: src_word = {FW_REV, 24'h0};
      SEL_ID1: begin
        src_word = ID1_WORD;
        src_len = ID_LEN;
        src_crc = 1'b1;
      end
      SEL_ID2: begin
        src_word = ID2_WORD;
        src_len = ID_LEN;
        src_crc = 1'b1;
      end
      SEL_NONE: src_word = 32'h0;
    endcase
  end

  // Bus sampling
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_in;
      sda_prev_q <= sda_in;
    end
  end

  // Byte engine
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h0;
      byte_idx_q <= 2'h0;
      ack_q <= 1'b0;
      rd_xfer_q <= 1'b0;
      mack_q <= 1'b0;
      tx_buf_q <= 32'h0;
      tx_left_q <= 3'h0;
      crc_pend_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (start_seen) begin
      state_q <= ST_RX;
      bit_cnt_q <= 4'h0;
      byte_idx_q <= 2'h0;
      rd_xfer_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (stop_seen) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else if (load_first || load_next || load_crc) begin
      state_q <= ST_TX;
      bit_cnt_q <= 4'h1;
      // hold clock while first bit settles, only when leaving ST_HOLD
      scl_oe_q <= (state_q == ST_HOLD);
      if (load_first) begin
        tx_buf_q <= src_word;
        tx_left_q <= src_len;
        crc_pend_q <= src_crc;
        sda_oe_q <= ~src_word[31];
        shift_q <= {src_word[30:24], 1'b0};
      end else if (load_next) begin
        tx_buf_q <= tx_buf_q << 8;
        tx_left_q <= tx_left_q - 3'h1;
        sda_oe_q <= ~tx_buf_q[23];
        shift_q <= {tx_buf_q[22:16], 1'b0};
      end else begin
        crc_pend_q <= 1'b0;
        sda_oe_q <= ~cif.value[7];
        shift_q <= {cif.value[6:0], 1'b0};
      end
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_in};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            ack_q <= rx_ack;
            sda_oe_q <= rx_ack;
            state_q <= ST_RACK;
            bit_cnt_q <= 4'h0;
            if (byte_idx_q != 2'h3) begin
              byte_idx_q <= byte_idx_q + 2'h1;
            end
            if (byte_idx_q == 2'h0) begin
              rd_xfer_q <= shift_q[0] & addr_ok;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            if (!ack_q) begin
              state_q <= ST_IDLE;
            end else if (rd_xfer_q) begin
              state_q <= ST_HOLD;
              scl_oe_q <= 1'b1;
            end else begin
              state_q <= ST_RX;
            end
          end
        end
        ST_TX: begin
          scl_oe_q <= 1'b0;
          if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              sda_oe_q <= 1'b0;
              state_q <= ST_TACK;
            end else begin
              sda_oe_q <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_in;
          end else if (scl_fall) begin
            state_q <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          scl_oe_q <= 1'b1;
        end
      endcase
    end
  end

  // Command decode and configuration
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_q <= 8'h0;
      rd_sel_q <= SEL_NONE;
      reg1_q <= `REG1_RESET;
      reg2_q <= `REG2_RESET;
      reg3_q <= `REG3_RESET;
      caddr_q <= 8'h0;
      cdata_q <= 8'h0;
      cwr_q <= 1'b0;
    end else begin
      cwr_q <= 1'b0;
      if (cmd_strobe) begin
        cmd_q <= shift_q;
        unique case (shift_q)
          `CMD_HUM_HOLD, `CMD_HUM_POLL: rd_sel_q <= SEL_HUM;
          `CMD_TEMP_HOLD, `CMD_TEMP_POLL: rd_sel_q <= SEL_TEMP;
          `CMD_AUX: rd_sel_q <= SEL_AUX;
          `CMD_LAST_TEMP: rd_sel_q <= SEL_LAST_T;
          `CMD_RD_REG2: rd_sel_q <= SEL_REG2;
          `CMD_RD_REG1: rd_sel_q <= SEL_REG1;
          `CMD_RD_REG3: rd_sel_q <= SEL_REG3;
          `CMD_RESET: begin
            reg1_q <= `REG1_RESET;
            reg2_q <= `REG2_RESET;
            reg3_q <= `REG3_RESET;
            rd_sel_q <= SEL_NONE;
          end
          default: rd_sel_q <= SEL_NONE;
        endcase
      end
      if (arg_strobe) begin
        unique case (cmd_q)
          `CMD_WR_REG2: reg2_q <= shift_q;
          `CMD_WR_REG1: reg1_q <= shift_q;
          `CMD_WR_REG3: reg3_q <= shift_q;
          `CMD_WR_COEF: caddr_q <= shift_q;
          `CMD_RD_COEF: begin
            caddr_q <= shift_q;
            rd_sel_q <= (shift_q == `SUB_FW) ? SEL_FW : SEL_COEF;
          end
          `CMD_ID1: begin
            if (shift_q == `SUB_ID1) begin
              rd_sel_q <= SEL_ID1;
            end
          end
          `CMD_ID2: begin
            if (shift_q == `SUB_ID2) begin
              rd_sel_q <= SEL_ID2;
            end
          end
          default: cdata_q <= cdata_q;
        endcase
      end
      if (data_strobe && cmd_q == `CMD_WR_COEF &&
          caddr_q >= `COEF_LO && caddr_q <= `COEF_HI) begin
        cdata_q <= shift_q;
        cwr_q <= 1'b1;
      end
    end
  end

  // Conversion tracking
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      poll_q <= 1'b0;
      start_q <= 1'b0;
      abort_q <= 1'b0;
      kind_q <= CONV_HUM;
    end else begin
      start_q <= 1'b0;
      abort_q <= 1'b0;
      if (conv_done) begin
        busy_q <= 1'b0;
      end
      if (cmd_strobe) begin
        unique case (shift_q)
          `CMD_HUM_HOLD, `CMD_HUM_POLL: begin
            start_q <= 1'b1;
            busy_q <= 1'b1;
            kind_q <= CONV_HUM;
            poll_q <= shift_q == `CMD_HUM_POLL;
          end
          `CMD_TEMP_HOLD, `CMD_TEMP_POLL: begin
            start_q <= 1'b1;
            busy_q <= 1'b1;
            kind_q <= CONV_TEMP;
            poll_q <= shift_q == `CMD_TEMP_POLL;
          end
          `CMD_AUX: begin
            start_q <= 1'b1;
            busy_q <= 1'b1;
            kind_q <= CONV_AUX;
            poll_q <= reg2_q[`REG2_POLL_BIT];
          end
          `CMD_RESET: begin
            abort_q <= 1'b1;
            busy_q <= 1'b0;
            poll_q <= 1'b0;
          end
          default: busy_q <= busy_q & ~conv_done;
        endcase
      end
    end
  end

  // Result capture
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_q <= 16'h0;
      last_temp_q <= 16'h0;
    end else if (conv_done && busy_q) begin
      unique case (kind_q)
        CONV_HUM: begin
          result_q <= {conv_result[15:2], `HUM_TAIL};
          last_temp_q <= {conv_comp_temp[15:2], `TEMP_TAIL};
        end
        CONV_TEMP: result_q <= {conv_result[15:2], `TEMP_TAIL};
        CONV_AUX: result_q <= conv_result;
      endcase
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign conv_start = start_q;
  assign conv_kind = kind_q;
  assign conv_abort = abort_q;
  assign coef_wr = cwr_q;
  assign coef_addr = caddr_q;
  assign coef_wdata = cdata_q;
  assign user_reg1 = reg1_q;
  assign user_reg2 = reg2_q;
  assign user_reg3 = reg3_q;

endmodule : humidity_sensor_i2c_command_port

// file: hs_monitor.sv
/*
  Checker of the command port pins: stretching, data stability, pulses,
  coefficient range and reset command effects.
  Assumes it is bound to the top module of the command port.
*/
`timescale 1ns/1ps
module hs_monitor
  import hs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Two-wire bus
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Front end and memory
  input wire logic conv_start,
  input wire conv_type conv_kind,
  input wire logic conv_abort,
  input wire logic conv_done,
  input wire logic coef_wr,
  input wire logic [7:0] coef_addr,
  // Configuration
  input wire logic [7:0] user_reg1,
  input wire logic [7:0] user_reg2,
  input wire logic [7:0] user_reg3
);
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_PINS_LOW: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("open-drain data value not zero");
  AST_STRETCH_END: assert property (scl_oe && conv_done |-> ##3 !scl_oe)
    else $error("clock stretch kept after conversion done");
  AST_STRETCH_LOW: assert property ($rose(scl_oe) |-> !scl_in)
    else $error("clock stretch began while clock high");
  AST_DATA_STABLE: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data line changed while clock high");
  AST_DRIVE_LOW: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data drive began while clock high");
  AST_START_ONCE: assert property (
    conv_start |=> !conv_start && conv_kind == $past(conv_kind))
    else $error("start not a single pulse with stable kind");
  AST_COEF_RANGE: assert property (
    coef_wr |-> coef_addr >= 8'h82 && coef_addr <= 8'hb7)
    else $error("coefficient write outside valid locations");
  AST_COEF_PULSE: assert property (coef_wr |=> !coef_wr)
    else $error("coefficient write longer than one cycle");
  AST_ABORT_REGS: assert property (conv_abort |-> ##[0:2]
    (user_reg1 == 8'h00 && user_reg2 == 8'h00 && user_reg3 == 8'h00))
    else $error("reset command left configuration set");
  AST_ABORT_ALONE: assert property (conv_abort |-> !conv_start)
    else $error("abort and start together");
  AST_CFG_ON_LOW: assert property (
    !$stable({user_reg1, user_reg2, user_reg3}) |-> !scl_in)
    else $error("configuration changed while clock high");
endmodule : hs_monitor
bind humidity_sensor_i2c_command_port hs_monitor u_mon (.core_clk, .rst,
  .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .conv_start,
  .conv_kind, .conv_abort, .conv_done, .coef_wr, .coef_addr, .user_reg1,
  .user_reg2, .user_reg3);

// file: hs_bus_master.sv
/*
  Two-wire bus master model: start, stop, byte write and byte read.
  Assumes pulled-up wires resolved by the bench; tasks run on falling edges.
*/
`timescale 1ns/1ps
module hs_bus_master (
  // Clock and wire levels
  input wire logic core_clk,
  input wire logic scl,
  input wire logic sda,
  // Pulls, high drives the wire low
  output logic scl_lo,
  output logic sda_lo
);
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  task automatic half();
    repeat (6) @(negedge core_clk);
  endtask : half
  task automatic rise();
    int n;
    n = 0;
    scl_lo = 1'b0;
    while (scl !== 1'b1 && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    half();
  endtask : rise
  task automatic start();
    sda_lo = 1'b0;
    half();
    rise();
    sda_lo = 1'b1;
    half();
    scl_lo = 1'b1;
    half();
  endtask : start
  task automatic stop();
    sda_lo = 1'b1;
    half();
    rise();
    sda_lo = 1'b0;
    half();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_lo = ~b;
    half();
    rise();
    r = sda;
    scl_lo = 1'b1;
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask : rbyte
endmodule : hs_bus_master

// file: testbench.sv
/*
  Self-checking bench of the command port: registers, conversions,
  coefficients, identity words and the reset command over the bus.
  Assumes the master model and the monitor are compiled before it.
*/
`timescale 1ns/1ps
module testbench;
  import hs_pkg::*;
  localparam logic [6:0] DEV = 7'h41;
  localparam logic [31:0] ID1 = 32'h1a2b3c4d; // arbitrary value
  localparam logic [31:0] ID2 = 32'h55667788; // arbitrary value
  localparam logic [7:0] FW = 8'h3e; // arbitrary value
  localparam logic [7:0] WR [3] = '{8'he6, 8'h50, 8'h51};
  localparam logic [7:0] RD [3] = '{8'he7, 8'h10, 8'h11};
  localparam logic [7:0] VAL [3] = '{8'h55, 8'h25, 8'h3c};
  localparam logic [7:0] MC [4] = '{8'he5, 8'hf5, 8'he3, 8'hf3};
  logic core_clk, rst, scl_oe, sda_oe, m_scl, m_sda;
  logic sel = 1'b1;
  logic conv_start, conv_abort, coef_wr, conv_done = 1'b0;
  conv_type conv_kind, kind_seen;
  logic [15:0] raw = 16'h6789, ctmp = 16'habcd;
  logic [7:0] coef_addr, coef_wdata, last_addr, last_data;
  logic [7:0] wr_cnt = 8'h00, ab_cnt = 8'h00;
  logic [7:0] user_reg1, user_reg2, user_reg3;
  int cnt = 0, bad_count = 0, num_checks = 0;
  wire scl = !(scl_oe | m_scl);
  wire sda = !(sda_oe | m_sda);
  wire [23:0] regs = {user_reg1, user_reg2, user_reg3};
  humidity_sensor_i2c_command_port #(.ID1_WORD(ID1), .ID2_WORD(ID2),
    .FW_REV(FW), .ID_BYTES(4)) DUT (.core_clk(core_clk), .rst(rst),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .address_select_pin(sel), .conv_start(conv_start),
    .conv_kind(conv_kind), .conv_abort(conv_abort), .conv_done(conv_done),
    .conv_result(raw), .conv_comp_temp(ctmp), .coef_wr(coef_wr),
    .coef_addr(coef_addr), .coef_wdata(coef_wdata),
    .coef_rdata(coef_addr ^ 8'h5a), .user_reg1(user_reg1),
    .user_reg2(user_reg2), .user_reg3(user_reg3));
  hs_bus_master mst (.core_clk(core_clk), .scl(scl), .sda(sda),
    .scl_lo(m_scl), .sda_lo(m_sda));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Front end and coefficient memory
  always @(negedge core_clk) begin
    conv_done <= 1'b0;
    if (conv_start) begin
      kind_seen <= conv_kind;
      cnt <= 400;
    end else if (conv_abort) cnt <= 0;
    else if (cnt == 1) begin
      conv_done <= 1'b1;
      cnt <= 0;
    end else if (cnt > 0) cnt <= cnt - 1;
    if (conv_abort) ab_cnt <= ab_cnt + 8'h01;
    if (coef_wr) begin
      wr_cnt <= wr_cnt + 8'h01;
      last_addr <= coef_addr;
      last_data <= coef_wdata;
    end
  end
  function automatic logic [7:0] crc8(input logic [39:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n * 8; i++)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[39 - i]) ? 8'h31 : 8'h00);
    return c;
  endfunction : crc8
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1
  task automatic send(input logic [23:0] b, input int n, input logic stp);
    logic a;
    mst.start();
    mst.wbyte({DEV, 1'b0}, a);
    cmp1(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.wbyte(b[23 - 8 * i -: 8], a);
      cmp1(a, 1'b1);
    end
    if (stp) mst.stop();
  endtask : send
  task automatic rd(input logic [39:0] v, input int n, input logic ack_last,
                    input logic refuse);
    logic a;
    logic [7:0] d;
    int t;
    t = 0;
    mst.start();
    mst.wbyte({DEV, 1'b1}, a);
    while (a !== 1'b1 && t < 40) begin
      mst.stop();
      t++;
      mst.start();
      mst.wbyte({DEV, 1'b1}, a);
    end
    cmp1(a, 1'b1);
    cmp1(t != 0, refuse);
    for (int i = 0; i < n; i++) begin
      mst.rbyte(i < n - 1 || ack_last, d);
      cmp8(d, v[39 - 8 * i -: 8]);
    end
    mst.rbyte(1'b0, d);
    cmp8(d, 8'hff);
    mst.stop();
  endtask : rd
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
  initial begin
    logic a;
    logic [7:0] d;
    logic [15:0] w;
    logic [39:0] v;
    rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    mst.start();
    mst.wbyte({DEV[6:1], 1'b0, 1'b0}, a);
    cmp1(a, 1'b0);
    mst.stop();
    sel = 1'b0;
    mst.start();
    mst.wbyte({DEV[6:1], 1'b0, 1'b0}, a);
    cmp1(a, 1'b1);
    mst.stop();
    sel = 1'b1;
    note("address");
    for (int i = 0; i < 3; i++) begin
      send({WR[i], VAL[i], 8'h00}, 2, 1'b1);
      cmp8(regs[23 - 8 * i -: 8], VAL[i]);
      send({RD[i], 16'h0000}, 1, 1'b0);
      rd({VAL[i], 32'h0}, 1, 1'b0, 1'b0);
    end
    note("registers");
    for (int i = 0; i < 4; i++) begin
      if (i == 2) ctmp = 16'h1111;
      w = {raw[15:2], (i < 2) ? 2'b10 : 2'b00};
      v = {w, crc8({w, 24'h0}, 2), 16'h0};
      send({MC[i], 16'h0000}, 1, i[0]);
      rd(v, (i == 3) ? 2 : 3, 1'b0, i[0]);
      cmp8({6'h00, kind_seen}, (i < 2) ? 8'h00 : 8'h01);
    end
    send({8'he0, 16'h0000}, 1, 1'b0);
    rd({16'habcc, 24'h0}, 2, 1'b1, 1'b0);
    note("conversions");
    send({8'h50, 8'h40, 8'h00}, 2, 1'b1);
    raw = 16'h8000;
    send({8'hee, 16'h0000}, 1, 1'b1);
    rd({16'h8000, 24'h0}, 2, 1'b1, 1'b1);
    cmp8({6'h00, kind_seen}, 8'h02);
    note("voltage");
    send({8'hc5, 8'h90, 8'h4c}, 3, 1'b1);
    send({8'hc5, 8'h20, 8'h11}, 3, 1'b1);
    send({8'hc5, 8'hb7, 8'h22}, 3, 1'b1);
    cmp8(wr_cnt, 8'h02);
    cmp8(last_addr, 8'hb7);
    cmp8(last_data, 8'h22);
    send({8'h84, 8'h90, 8'h00}, 2, 1'b0);
    rd({8'hca, 32'h0}, 1, 1'b0, 1'b0);
    note("coefficients");
    send({8'hfa, 8'h0f, 8'h00}, 2, 1'b0);
    rd({ID1, crc8({ID1, 8'h0}, 4)}, 5, 1'b0, 1'b0);
    send({8'hfc, 8'hc9, 8'h00}, 2, 1'b0);
    rd({ID2, crc8({ID2, 8'h0}, 4)}, 5, 1'b0, 1'b0);
    send({8'h84, 8'hb8, 8'h00}, 2, 1'b0);
    rd({FW, 32'h0}, 1, 1'b0, 1'b0);
    note("identity");
    send({8'hee, 16'h0000}, 1, 1'b1);
    send({8'hfe, 16'h0000}, 1, 1'b1);
    cmp8(ab_cnt, 8'h01);
    cmp8(user_reg1 | user_reg2 | user_reg3, 8'h00);
    mst.start();
    mst.wbyte({DEV, 1'b1}, a);
    cmp1(a, 1'b1);
    mst.rbyte(1'b0, d);
    mst.stop();
    note("reset");
    test_done();
  end
endmodule : testbench
